// [asu_top.sv]
// Asynchronous / clock synchronous serial unit with Wishbone registers
// How it works
// - Mode bit 7 picks async framing or clock synchronous operation
// - Async: bit6 seven bits, bit5 parity, bit2 multiproc, bit3 stops
// - Sync: eight data bits only, overrun is the only receive error
// - Async: internal baud or bit clock out, or 16x clock input
// - Sync: internal clock driven out, or external clock taken in
// - Async clock out runs at bit rate, rising mid data bit
// - Line idles high, low start bit opens each character
// - Receiver aligns to start edge, samples on eighth 16x pulse
// - Transmit start, data LSB first, parity/multiproc, stops, mark
// - Independent paths, each with holding plus shift register
// - Transmit disable sets empty flag, resets shifter; rx keeps flags
// - Empty flag low: load shifter, set flag, start, empty irq
// - At frame end reload if data waits, else set done; async line marks
// - Parity generated and checked as even or odd per mode bit
// - Stop bit must be one, only the first one checked
// - Good character goes to holding register, sets full flag
// - Character ending while full sets overrun, data dropped
// - Framing or parity error sets flag, data still transferred
// - Any error flag halts reception until software clears it
// - Error flag with receive irq enable raises error irq
// - Baud tick from 1/4/16/64 prescale and bit rate value plus one
// - Bit rate register resets to all ones, always accessible
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "asu_regs.svh"
module asu_top import asu_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic tx_pin_o,
  input wire logic rx_pin_i,
  input wire logic serial_clk_pin_i,
  output logic serial_clk_pin_o,
  output logic serial_clk_pin_oe_o,
  output logic tx_empty_irq_o,
  output logic tx_done_irq_o,
  output logic rx_full_irq_o,
  output logic rx_err_irq_o
);
  asu_mode_t mode_q;
  asu_ctrl_t ctrl_q;
  asu_tx_st_t tx_st_q;
  asu_rx_st_t rx_st_q;
  logic [7:0] bit_rate_reg_q, tx_holding_reg_q, rx_holding_reg_q;
  logic txe_q, rxf_q, orun_q, ferr_q, perr_q, tdone_q, mpbt_q, mpbr_q;
  logic ack_q, req, wr, rd_go;
  logic [2:0] idx;
  logic [31:0] rdat_q;
  logic [16:0] bcnt_q, blim;
  logic int_tick, tick16, s_rise, s_fall, srun, ext, syn;
  logic [2:0] sck_s_q, rxd_s_q;
  logic sck_f_q, rxd_f_q, sck_rise, sck_fall, rx_fall;
  logic [3:0] tph_q, rph_q, tx_left_q, ridx_q;
  logic [11:0] tx_shift_reg_q, rx_shift_reg_q;
  logic tx_line_q, trs_q, tx_adv, tx_load, sck_q, sck_oe_q;
  logic rx_ok, rx_samp, rx_fin, rbit;
  logic [3:0] nd, rlast;
  logic hasp;
  logic [7:0] rdata;
  logic [11:0] ff;
  logic [3:0] fn;

  // Cycles of peripheral clock per 1/16 async bit (1/2 sync bit)
  function automatic logic [16:0] tick_limit(input logic [7:0] n,
                                             input logic [1:0] cks);
    logic [16:0] v;
    v = {9'h000, n} + 17'h00001;
    v = v << {cks, 1'b0};
    tick_limit = (v << 2) - 17'h00001;
  endfunction

  // Async frame bits after the start bit, LSB first, stops as ones
  function automatic logic [15:0] frame_of(input logic [7:0] d,
                                           input asu_mode_t m,
                                           input logic addr_flag_bit);
    logic [11:0] f;
    logic [3:0] n;
    logic p;
    f = 12'hFFF;
    n = m.seven_bit_select ? 4'h7 : 4'h8;
    f[7:0] = m.seven_bit_select ? {1'b1, d[6:0]} : d;
    p = ^(m.seven_bit_select ? {1'b0, d[6:0]} : d) ^ m.odd;
    if (m.multiproc_format) begin
      f[n] = addr_flag_bit;
      n = n + 4'h1;
    end else if (m.parity_on) begin
      f[n] = p;
      n = n + 4'h1;
    end
    n = n + (m.two_stop ? 4'h2 : 4'h1);
    frame_of = {n, f};
  endfunction

  // Wishbone classic slave, one wait state, unmapped reads give zero
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[4:2];
  assign wr = req & wb_we_i & ack_q & wb_sel_i[0];
  assign rd_go = req & ~ack_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= rd_go;
      if (rd_go) begin
        case (idx)
          `ASU_IDX_MODE: rdat_q <= {24'h000000, mode_q};
          `ASU_IDX_BRR: rdat_q <= {24'h000000, bit_rate_reg_q};
          `ASU_IDX_CTRL: rdat_q <= {24'h000000, ctrl_q};
          `ASU_IDX_TDR: rdat_q <= {24'h000000, tx_holding_reg_q};
          `ASU_IDX_STAT: rdat_q <= {24'h000000, txe_q, rxf_q, orun_q,
                                    ferr_q, perr_q, tdone_q, mpbr_q,
                                    mpbt_q};
          `ASU_IDX_RDR: rdat_q <= {24'h000000, rx_holding_reg_q};
          default: rdat_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Configuration registers; bit rate stays writable at all times
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= `ASU_MODE_RST;
      ctrl_q <= `ASU_CTRL_RST;
      bit_rate_reg_q <= `ASU_BRR_RST;
      tx_holding_reg_q <= 8'h00;
      mpbt_q <= 1'b0;
    end else if (wr) begin
      case (idx)
        `ASU_IDX_MODE: mode_q <= wb_dat_i[7:0];
        `ASU_IDX_BRR: bit_rate_reg_q <= wb_dat_i[7:0];
        `ASU_IDX_CTRL: ctrl_q <= wb_dat_i[7:0];
        `ASU_IDX_TDR: tx_holding_reg_q <= wb_dat_i[7:0];
        `ASU_IDX_STAT: mpbt_q <= wb_dat_i[`ASU_ST_MPBT];
        default: mpbt_q <= mpbt_q;
      endcase
    end
  end

  // Baud generator; free runs so the tick grid stays regular
  assign blim = tick_limit(bit_rate_reg_q, {mode_q.prescale_sel_hi,
                                            mode_q.prescale_sel_lo});
  // At or past the limit, so a smaller divisor never strands the count
  assign int_tick = (bcnt_q >= blim);
  always_ff @(posedge clk_i) begin
    if (rst_i || int_tick) begin
      bcnt_q <= 17'h00000;
    end else begin
      bcnt_q <= bcnt_q + 17'h00001;
    end
  end

  // Pin synchronisers: a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_s_q <= 3'h7;
      rxd_s_q <= 3'h7;
      sck_f_q <= 1'b1;
      rxd_f_q <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[1:0], serial_clk_pin_i};
      rxd_s_q <= {rxd_s_q[1:0], rx_pin_i};
      if (sck_s_q[1] == sck_s_q[2]) sck_f_q <= sck_s_q[2];
      if (rxd_s_q[1] == rxd_s_q[2]) rxd_f_q <= rxd_s_q[2];
    end
  end
  assign sck_rise = (sck_s_q[1] == sck_s_q[2]) & sck_s_q[2] & ~sck_f_q;
  assign sck_fall = (sck_s_q[1] == sck_s_q[2]) & ~sck_s_q[2] & sck_f_q;
  assign rx_fall = (rxd_s_q[1] == rxd_s_q[2]) & ~rxd_s_q[2] & rxd_f_q;

  // Clock source selection for both modes
  assign syn = mode_q.sync;
  assign ext = ctrl_q.clk_ext_select;
  assign tick16 = ~syn & (ext ? sck_rise : int_tick);
  assign srun = (tx_st_q == ASU_TX_RUN) | (rx_ok & ~rxf_q & syn);
  assign s_rise = syn & (ext ? sck_rise : (srun & int_tick & ~tph_q[0]));
  assign s_fall = syn & (ext ? sck_fall : (srun & int_tick & tph_q[0]));
  assign tx_adv = syn ? (s_fall & trs_q) : (tick16 & tph_q == `ASU_OVS_LAST);

  // Bit phase: 16 ticks per async bit, half periods in sync mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tph_q <= 4'h0;
    end else if (syn) begin
      // Last fall of a character parks the clock high, no stray pulse
      if (ext || !srun || (tx_adv && tx_left_q == 4'h1 && !tx_load)) begin
        tph_q <= 4'h1;
      end else if (int_tick) begin
        tph_q <= {3'h0, ~tph_q[0]};
      end
    end else if (tick16) begin
      tph_q <= tph_q + 4'h1;
    end
  end

  // Clock pin: async out high over the second half of each bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_q <= 1'b1;
      sck_oe_q <= 1'b0;
    end else begin
      sck_oe_q <= ~ext & (syn | ctrl_q.clk_out_enable);
      sck_q <= syn ? tph_q[0] : tph_q[3];
    end
  end
  assign serial_clk_pin_o = sck_q;
  assign serial_clk_pin_oe_o = sck_oe_q;

  // Transmitter; async loads only on a bit boundary of the phase grid
  assign tx_load = ctrl_q.transmit_enable & ~txe_q &
                   (syn ? (tx_st_q == ASU_TX_IDLE ||
                           (tx_adv && tx_left_q == 4'h1))
                        : tx_adv && (tx_st_q == ASU_TX_IDLE ||
                                     tx_left_q == 4'h1));
  assign {fn, ff} = frame_of(tx_holding_reg_q, mode_q, mpbt_q);
  always_ff @(posedge clk_i) begin
    if (rst_i || !ctrl_q.transmit_enable) begin
      tx_st_q <= ASU_TX_IDLE;
      tx_line_q <= 1'b1;
      tx_shift_reg_q <= 12'hFFF;
      tx_left_q <= 4'h0;
      trs_q <= 1'b0;
    end else begin
      if (s_rise) trs_q <= 1'b1;
      if (tx_load && syn) begin
        tx_st_q <= ASU_TX_RUN;
        tx_line_q <= tx_holding_reg_q[0];
        tx_shift_reg_q <= {5'h1F, tx_holding_reg_q[7:1]};
        tx_left_q <= 4'h8;
        trs_q <= 1'b0;
      end else if (tx_load) begin
        tx_st_q <= ASU_TX_RUN;
        tx_line_q <= 1'b0;
        tx_shift_reg_q <= ff;
        tx_left_q <= fn + 4'h1;
      end else if (tx_adv && tx_st_q == ASU_TX_RUN) begin
        trs_q <= 1'b0;
        if (tx_left_q == 4'h1) begin
          tx_st_q <= ASU_TX_IDLE;
          if (!syn) tx_line_q <= 1'b1;
        end else begin
          tx_line_q <= tx_shift_reg_q[0];
          tx_shift_reg_q <= {1'b1, tx_shift_reg_q[11:1]};
          tx_left_q <= tx_left_q - 4'h1;
        end
      end
    end
  end
  assign tx_pin_o = tx_line_q;

  // Transmit flags: hardware set wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txe_q <= 1'b1;
      tdone_q <= 1'b1;
    end else begin
      if (!ctrl_q.transmit_enable || tx_load) begin
        txe_q <= 1'b1;
      end else if (wr && idx == `ASU_IDX_STAT &&
                   !wb_dat_i[`ASU_ST_TXE]) begin
        txe_q <= 1'b0;
      end
      if (tx_adv && tx_st_q == ASU_TX_RUN && tx_left_q == 4'h1 &&
          !tx_load) begin
        tdone_q <= 1'b1;
      end else if (tx_load || (wr && idx == `ASU_IDX_STAT &&
                               !wb_dat_i[`ASU_ST_TDONE])) begin
        tdone_q <= 1'b0;
      end
    end
  end

  // Receive format decode
  assign nd = (mode_q.seven_bit_select && !syn) ? 4'h7 : 4'h8;
  assign hasp = ~syn & (mode_q.multiproc_format | mode_q.parity_on);
  assign rlast = syn ? `ASU_SYNC_LAST : nd + {3'h0, hasp};
  assign rx_ok = ctrl_q.rx_enable & ~(orun_q | ferr_q | perr_q);
  assign rbit = rxd_f_q;
  assign rx_samp = syn ? (s_rise && rx_st_q == ASU_RX_DATA)
                       : (tick16 && rph_q == `ASU_MID_PH &&
                          rx_st_q != ASU_RX_IDLE);
  assign rx_fin = rx_samp && rx_st_q == ASU_RX_DATA && ridx_q == rlast;
  always_comb begin
    rdata = rx_shift_reg_q[7:0];
    if (nd == 4'h7) rdata[7] = 1'b0;
  end

  // Receive sequencer; leaving receive enable keeps all flags
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_ok) begin
      rx_st_q <= ASU_RX_IDLE;
      rph_q <= 4'h0;
      ridx_q <= 4'h0;
      rx_shift_reg_q <= 12'h000;
    end else begin
      if (tick16) rph_q <= rph_q + 4'h1;
      case (rx_st_q)
        ASU_RX_IDLE: begin
          ridx_q <= 4'h0;
          if (syn) begin
            rx_st_q <= ASU_RX_DATA;
          end else if (rx_fall) begin
            rph_q <= 4'h0;
            rx_st_q <= ASU_RX_START;
          end
        end
        ASU_RX_START: begin
          if (rx_samp) rx_st_q <= rbit ? ASU_RX_IDLE : ASU_RX_DATA;
        end
        ASU_RX_DATA: begin
          if (rx_samp) begin
            rx_shift_reg_q[ridx_q] <= rbit;
            ridx_q <= ridx_q + 4'h1;
            if (rx_fin) begin
              ridx_q <= 4'h0;
              if (!syn) rx_st_q <= ASU_RX_IDLE;
            end
          end
        end
        default: rx_st_q <= ASU_RX_IDLE;
      endcase
    end
  end

  // Receive checks and flags; a hardware set beats a software clear
  logic pbad, fbad;
  assign pbad = hasp & ~mode_q.multiproc_format &
                ((^rdata ^ rx_shift_reg_q[nd]) != mode_q.odd);
  assign fbad = ~syn & ~rbit;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxf_q <= 1'b0;
      orun_q <= 1'b0;
      ferr_q <= 1'b0;
      perr_q <= 1'b0;
      mpbr_q <= 1'b0;
      rx_holding_reg_q <= 8'h00;
    end else begin
      if (wr && idx == `ASU_IDX_STAT) begin
        if (!wb_dat_i[`ASU_ST_RXF]) rxf_q <= 1'b0;
        if (!wb_dat_i[`ASU_ST_ORUN]) orun_q <= 1'b0;
        if (!wb_dat_i[`ASU_ST_FERR]) ferr_q <= 1'b0;
        if (!wb_dat_i[`ASU_ST_PERR]) perr_q <= 1'b0;
      end
      if (rx_fin) begin
        if (rxf_q) begin
          orun_q <= 1'b1;
        end else begin
          rx_holding_reg_q <= rdata;
          mpbr_q <= mode_q.multiproc_format & rx_shift_reg_q[nd];
          if (fbad) ferr_q <= 1'b1;
          if (pbad && !syn) perr_q <= 1'b1;
          if (!fbad && !pbad) rxf_q <= 1'b1;
        end
      end
    end
  end

  // Interrupt requests are levels, flag gated by enable
  assign tx_empty_irq_o = txe_q & ctrl_q.tx_empty_irq_en;
  assign tx_done_irq_o = tdone_q & ctrl_q.tx_done_irq_en;
  assign rx_full_irq_o = rxf_q & ctrl_q.rx_irq_en;
  assign rx_err_irq_o = (orun_q | ferr_q | perr_q) &
                        ctrl_q.rx_irq_en;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_async_load;
    tx_load && !syn;
  endsequence
  sequence s_start_out;
    !tx_pin_o && txe_q;
  endsequence
  a_load_start: assert property (s_async_load |=> s_start_out)
    else $error("start bit or empty flag missing after load");
  a_te_off: assert property (!ctrl_q.transmit_enable |=> txe_q &&
    tx_pin_o && tx_st_q == ASU_TX_IDLE)
    else $error("transmit disable did not reset");
  a_idle_mark: assert property (tx_st_q == ASU_TX_IDLE && !syn &&
    !tx_load |=> tx_pin_o)
    else $error("line not marking while idle");
  a_brr_reset: assert property ($fell(rst_i) |-> bit_rate_reg_q == 8'hFF)
    else $error("bit rate register not all ones after reset");
  a_overrun: assert property (rx_fin && rxf_q |=> orun_q &&
    $stable(rx_holding_reg_q))
    else $error("overrun mishandled");
  a_err_hold: assert property ((orun_q || ferr_q || perr_q) |=>
    rx_st_q == ASU_RX_IDLE && !$rose(rxf_q))
    else $error("reception went on with an error flag");
  a_err_irq: assert property (rx_err_irq_o == (ctrl_q.rx_irq_en &&
    (orun_q || ferr_q || perr_q)))
    else $error("error irq wrong");
  a_mid_sample: assert property (rx_samp && !syn |->
    rph_q == 4'h7 && tick16)
    else $error("sample not on eighth pulse");
  a_clk_mid: assert property (!syn && tick16 && tph_q == 4'h7 |=> ##1
    sck_q)
    else $error("async clock not high from bit centre");
  a_tick_wrap: assert property (int_tick |=> bcnt_q == 17'h00000 ##1
    bcnt_q == 17'h00001)
    else $error("baud counter did not restart");
  a_frame_bad: assert property (rx_fin && !rxf_q && fbad |=> ferr_q &&
    rx_holding_reg_q == $past(rdata))
    else $error("framing error data not kept");
endmodule

// [asu_regs.svh]
// Register indices, field positions, reset values and counts of the unit
`ifndef ASU_REGS_SVH
`define ASU_REGS_SVH
`define ASU_IDX_MODE 3'h0
`define ASU_IDX_BRR 3'h1
`define ASU_IDX_CTRL 3'h2
`define ASU_IDX_TDR 3'h3
`define ASU_IDX_STAT 3'h4
`define ASU_IDX_RDR 3'h5
`define ASU_MODE_RST 8'h00
`define ASU_CTRL_RST 8'h00
`define ASU_BRR_RST 8'hFF
`define ASU_ST_TXE 7
`define ASU_ST_RXF 6
`define ASU_ST_ORUN 5
`define ASU_ST_FERR 4
`define ASU_ST_PERR 3
`define ASU_ST_TDONE 2
`define ASU_ST_MPBR 1
`define ASU_ST_MPBT 0
`define ASU_OVS_LAST 4'hF
`define ASU_MID_PH 4'h7
`define ASU_SYNC_LAST 4'h7
`endif

// [asu_pkg.sv]
// Types shared by the serial unit
package asu_pkg;
  typedef struct packed {
    logic sync;
    logic seven_bit_select;
    logic parity_on;
    logic odd;
    logic two_stop;
    logic multiproc_format;
    logic prescale_sel_hi;
    logic prescale_sel_lo;
  } asu_mode_t;
  typedef struct packed {
    logic tx_empty_irq_en;
    logic rx_irq_en;
    logic transmit_enable;
    logic rx_enable;
    logic rsv;
    logic tx_done_irq_en;
    logic clk_ext_select;
    logic clk_out_enable;
  } asu_ctrl_t;
  typedef enum logic {ASU_TX_IDLE, ASU_TX_RUN} asu_tx_st_t;
  typedef enum logic [1:0] {ASU_RX_IDLE, ASU_RX_START, ASU_RX_DATA}
    asu_rx_st_t;
endpackage

// [asu_far_end.sv]
// Far-end serial device: frame sender and centre-sampling receiver
`timescale 1ns/10ps
module asu_far_end #(
  parameter int BIT_CLKS = 64
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  int rx_len = 9;
  logic [11:0] cap_q;
  logic [11:0] got_q[$];
  // Line marks until the first frame
  initial line_o = 1'h1;
  // Low start, bits first to last, then one bit of mark
  task automatic send(input logic [11:0] bits, input int n);
    @(posedge clk_i);
    line_o <= 1'h0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int k = 0; k < n; k++) begin
      line_o <= bits[k];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= 1'h1;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask
  // Start edge, then one sample at the centre of each later bit
  always begin
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    cap_q = 12'h000;
    for (int k = 0; k < rx_len; k++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      cap_q[k] = line_i;
    end
    got_q.push_back(cap_q);
  end
endmodule

// [tb.sv]
// Self-checking bench for the serial unit: registers, frames, flags, irqs
`timescale 1ns/10ps
`include "asu_regs.svh"
module tb import asu_pkg::*; ;
  localparam logic [2:0] MODE = `ASU_IDX_MODE;
  localparam logic [2:0] BRR = `ASU_IDX_BRR;
  localparam logic [2:0] CTRL = `ASU_IDX_CTRL;
  localparam logic [2:0] TDR = `ASU_IDX_TDR;
  localparam logic [2:0] STAT = `ASU_IDX_STAT;
  localparam logic [2:0] RDR = `ASU_IDX_RDR;
  // Per format: mode, status write, expected frame after the start bit
  localparam logic [7:0] MD [3] = '{8'h78, 8'h68, 8'h24};
  localparam logic [7:0] SW [3] = '{8'h7E, 8'h7E, 8'h7F};
  localparam logic [11:0] EX [3] = '{12'h3D5, 12'h355, 12'h3D5};
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic wb_cyc = 1'h0;
  logic wb_stb = 1'h0;
  logic wb_we = 1'h0;
  logic [3:0] wb_sel = 4'h1;
  logic [3:0] sel_v = 4'h1;
  logic [4:0] wb_adr = 5'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, tx_pin_o, rx_line, clk_o, clk_oe;
  logic txe_irq, tdn_irq, rxf_irq, rxe_irq;
  logic [7:0] rd_q;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  logic [1:0] sck_div = 2'h0;

  asu_top DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tx_pin_o(tx_pin_o), .rx_pin_i(rx_line),
    .serial_clk_pin_i(sck_div[1]),
    .serial_clk_pin_o(clk_o), .serial_clk_pin_oe_o(clk_oe),
    .tx_empty_irq_o(txe_irq), .tx_done_irq_o(tdn_irq),
    .rx_full_irq_o(rxf_irq), .rx_err_irq_o(rxe_irq)
  );
  asu_far_end #(.BIT_CLKS(64)) u_far (
    .clk_i(clk_i), .line_i(tx_pin_o), .line_o(rx_line)
  );

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  // External clock pin at 16x a 64 cycle bit, never stopped
  always @(posedge clk_i) sck_div <= sck_div + 2'h1;

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard; the whole run needs about 9k cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({11'h0, got}, {11'h0, exp});
  endtask

  // Classic single cycle; request held until ack is seen at an edge
  task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we <= w;
    wb_sel <= sel_v;
    wb_adr <= {i, 2'h0};
    wb_dat <= {24'h0, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    rd_q = wb_dat_o[7:0];
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    // Callers look at outputs only once the ack edge has settled
    @(negedge clk_i);
  endtask

  task automatic rdc(input logic [2:0] i, input logic [7:0] m,
                     input logic [7:0] e);
    bus(1'h0, i, 8'h00);
    chk({4'h0, rd_q & m}, {4'h0, e});
  endtask

  // Poll status until the given bit reads one
  task automatic wait_st(input int b);
    do bus(1'h0, STAT, 8'h00); while (rd_q[b] !== 1'h1);
  endtask

  task automatic wait_frames(input int n);
    while (u_far.got_q.size() < n) @(posedge clk_i);
  endtask

  // Disable both paths before touching the format
  task automatic setup(input logic [7:0] m, input logic [7:0] c);
    bus(1'h1, CTRL, 8'h00);
    bus(1'h1, MODE, m);
    bus(1'h1, CTRL, c);
    u_far.got_q.delete();
  endtask

  task automatic t_reset();
    chkb(tx_pin_o, 1'h1);
    rdc(BRR, 8'hFF, 8'hFF);
    rdc(STAT, 8'hFC, 8'h84);
    rdc(3'h6, 8'hFF, 8'h00);
    sel_v = 4'h0;
    bus(1'h1, BRR, 8'h12);
    sel_v = 4'h1;
    rdc(BRR, 8'hFF, 8'hFF);
    bus(1'h1, BRR, 8'h00);
    rdc(BRR, 8'hFF, 8'h00);
  endtask

  task automatic t_tx();
    setup(8'h00, 8'hF5);
    chkb(txe_irq, 1'h1);
    u_far.rx_len = 9;
    bus(1'h1, TDR, 8'hA5);
    bus(1'h1, STAT, 8'h7E);
    chkb(clk_oe, 1'h1);
    wait_st(7);
    chkb(rd_q[2], 1'h0);
    chkb(tdn_irq, 1'h0);
    bus(1'h1, TDR, 8'h3C);
    bus(1'h1, STAT, 8'h7E);
    wait_frames(2);
    chk(u_far.got_q[0], 12'h1A5);
    chk(u_far.got_q[1], 12'h13C);
    wait_st(2);
    chkb(tdn_irq, 1'h1);
  endtask

  task automatic t_fmt();
    u_far.rx_len = 10;
    for (int k = 0; k < 3; k++) begin
      setup(MD[k], 8'h20);
      bus(1'h1, TDR, 8'hD5);
      bus(1'h1, STAT, SW[k]);
      wait_frames(1);
      chk(u_far.got_q[0], EX[k]);
    end
  endtask

  task automatic t_rx();
    setup(8'h00, 8'h70);
    u_far.rx_len = 9;
    // Far end sends while the unit transmits
    fork
      u_far.send(12'h196, 9);
      begin
        bus(1'h1, TDR, 8'h69);
        bus(1'h1, STAT, 8'h7E);
      end
    join
    wait_frames(1);
    chk(u_far.got_q[0], 12'h169);
    rdc(STAT, 8'h78, 8'h40);
    chkb(rxf_irq, 1'h1);
    rdc(RDR, 8'hFF, 8'h96);
    bus(1'h1, CTRL, 8'h40);
    rdc(STAT, 8'h78, 8'h40);
    rdc(RDR, 8'hFF, 8'h96);
    bus(1'h1, CTRL, 8'h50);
    u_far.send(12'h111, 9);
    rdc(STAT, 8'h78, 8'h60);
    rdc(RDR, 8'hFF, 8'h96);
    chkb(rxe_irq, 1'h1);
    bus(1'h1, STAT, 8'hBF);
    u_far.send(12'h122, 9);
    rdc(STAT, 8'h78, 8'h20);
    bus(1'h1, STAT, 8'h84);
    u_far.send(12'h05A, 9);
    rdc(STAT, 8'h78, 8'h10);
    rdc(RDR, 8'hFF, 8'h5A);
    bus(1'h1, STAT, 8'h84);
    setup(8'h60, 8'h50);
    u_far.send(12'h155, 9);
    rdc(STAT, 8'h78, 8'h40);
    bus(1'h1, STAT, 8'h84);
    u_far.send(12'h1D5, 9);
    rdc(STAT, 8'h78, 8'h08);
    rdc(RDR, 8'hFF, 8'h55);
  endtask

  // Transmit disable in mid-frame
  task automatic t_txoff();
    setup(8'h00, 8'h20);
    bus(1'h1, TDR, 8'h00);
    bus(1'h1, STAT, 8'h7E);
    while (tx_pin_o !== 1'h0) @(posedge clk_i);
    bus(1'h1, CTRL, 8'h00);
    rdc(STAT, 8'h80, 8'h80);
    chkb(tx_pin_o, 1'h1);
  endtask

  // Async transmit timed by the external 16x clock on the pin
  task automatic t_ext();
    setup(8'h00, 8'h22);
    u_far.rx_len = 9;
    bus(1'h1, TDR, 8'h5C);
    bus(1'h1, STAT, 8'h7E);
    chkb(clk_oe, 1'h0);
    wait_frames(1);
    chk(u_far.got_q[0], 12'h15C);
  endtask

  // Clock synchronous send on the internal clock, taken on clock rises
  task automatic t_sync();
    logic [7:0] cap;
    logic prev;
    int n;
    cap = 8'h00;
    n = 0;
    prev = 1'h1;
    setup(8'h80, 8'h20);
    bus(1'h1, TDR, 8'hC6);
    bus(1'h1, STAT, 8'h7E);
    // A stray ninth pulse after the last bit would show in the count
    repeat (120) begin
      @(posedge clk_i);
      if (clk_o && !prev) begin
        cap = {tx_pin_o, cap[7:1]};
        n++;
      end
      prev = clk_o;
    end
    chk({4'h0, cap}, 12'h0C6);
    chk(n[11:0], 12'h008);
    chkb(clk_oe, 1'h1);
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_tx();
    t_fmt();
    t_ext();
    t_rx();
    t_txoff();
    t_sync();
    report_and_stop();
  end
endmodule
